// ### verilog/serial_irq_regs.svh
// Register offsets, field positions, reset values and sizes of the serial interrupt block
`ifndef SERIAL_IRQ_REGS_SVH
`define SERIAL_IRQ_REGS_SVH
`define ADDR_CMD      8'h00
`define ADDR_ICTL     8'h04
`define ADDR_XOPT     8'h08
`define ADDR_STAT     8'h0c
`define ADDR_SCST     8'h10
`define ADDR_RXD      8'h14
`define ADDR_TXD      8'h18
`define ADDR_VEC      8'h1c
`define ICTL_TXIE     1
`define ICTL_PAR      2
`define ICTL_MODE_LO  3
`define ICTL_MODE_HI  4
`define XOPT_RXTHR    3
`define XOPT_TXLVL    5
`define STAT_RXAV     0
`define STAT_TEF      2
`define STAT_LOCK     3
`define VEC_RXP       0
`define VEC_TXP       1
`define VEC_IUS       2
`define VEC_ST_LO     4
`define VEC_ST_HI     5
`define TXLVL_RST     1'b1
`define RX_THRESHOLD  4'h4
`define TX_LOW_FULL   2'h3
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// ### verilog/serial_irq_pkg.sv
// Types of the serial interrupt block
package serial_irq_pkg;
  typedef enum logic [1:0] {
    RX_OFF     = 2'b00,
    RX_FIRST   = 2'b01,
    RX_ALL     = 2'b10,
    RX_SPECIAL = 2'b11
  } rx_mode_t;

  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_NEXT_CHR = 3'h1,
    CMD_ERR_RST  = 3'h2,
    CMD_TXP_RST  = 3'h3,
    CMD_IUS_RST  = 3'h4
  } cmd_t;

  typedef enum logic [1:0] {
    VS_TX      = 2'b00,
    VS_RX_CHAR = 2'b10,
    VS_RX_SPEC = 2'b11
  } vec_status_t;

  typedef struct packed {
    logic [7:0][11:0] mem;
    logic [2:0]       head;
    logic [3:0]       count;
  } store_state_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [7:0]  wbyte;
    logic        wlane;
    logic        tx_ie;
    logic        par_en;
    rx_mode_t    mode;
    logic        rx_thr;
    logic        tx_lvl;
    logic        armed;
    logic        first_pend;
    logic        special;
    logic        lock;
    logic        rx_pend;
    logic [7:0]  tx_entry;
    logic        entry_full;
    logic [2:0][7:0] tx_low;
    logic [1:0]  tx_cnt;
    logic        tx_written;
    logic [1:0]  tx_pend;
    logic        in_service;
    vec_status_t vstat;
    logic        irq;
    logic        entry_free;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        dma_req;
    logic        rx_ready;
  } chan_state_t;
endpackage : serial_irq_pkg

// ### verilog/rxq_if.sv
// Link between the channel logic and its receive data and status store
`timescale 1ns/1ps
interface rxq_if;
  logic        push;
  logic [7:0]  push_data;
  logic [3:0]  push_err;
  logic        pop;
  logic [3:0]  count;
  logic [7:0]  head_data;
  logic [3:0]  head_err;
  modport owner (output push, push_data, push_err, pop, input count, head_data, head_err);
  modport store (input push, push_data, push_err, pop, output count, head_data, head_err);
endinterface : rxq_if

// ### verilog/rx_store.sv
// Eight-deep receive store holding each data byte with its error status
`timescale 1ns/1ps
module rx_store
  import serial_irq_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Store port
  rxq_if.store     q
);
  store_state_t s_q;
  store_state_t s_d;
  logic         do_pop;
  logic         do_push;
  logic [2:0]   tail;

  always_comb begin
    s_d     = s_q;
    do_pop  = q.pop && (s_q.count != 4'h0);
    do_push = q.push && ((s_q.count != 4'h8) || do_pop);
    tail    = 3'(s_q.head + s_q.count[2:0]);
    if (do_push) begin
      s_d.mem[tail] = {q.push_err, q.push_data};
    end
    if (do_pop) begin
      s_d.head = 3'(s_q.head + 3'h1);
    end
    s_d.count = 4'(s_q.count + {3'h0, do_push} - {3'h0, do_pop});
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q.count     = s_q.count;
  assign q.head_data = s_q.mem[s_q.head][7:0];
  assign q.head_err  = s_q.mem[s_q.head][11:8];
endmodule : rx_store

// ### verilog/serial_irq.sv
// Receive and transmit interrupt-pending logic of one serial channel with AXI4-Lite registers
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "serial_irq_regs.svh"
// Operation
// - First-character mode flags first byte, clears on removal
// - Then silent until next-char command or special
// - Special raised after its byte read, then locks
// - Error-reset command releases lock; host reads status first
// - Lock freezes exit only; store keeps receiving
// - One pending/in-service flag; vector status distinguishes
// - All mode: pending while a byte at exit
// - All mode with threshold: pending at four bytes
// - All mode: special never locks the store
// - Special-only mode: only special bytes flag pending
// - Lock withholds DMA requests until unlocked
// - Transmit interrupt enable gates transmit interrupts
// - Level option set: pending when transmit store empties
// - Reset sets the transmit level option
// - Entry-free follows entry location only
// - Level option clear: request while three or fewer
// - Write drops request; returns as entry shifts down
// - Write or command clears; needs a prior write
// - Sync end of CRC sets pending only; entry-free unchanged
// - CRC interrupt latched on top; two resets needed
// - Receive mode is control bits four to three
// - Data read pops data and status together
module serial_irq
  import serial_irq_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read channels
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Receiver side
  input  wire logic        rx_push,
  input  wire logic [7:0]  rx_byte,
  input  wire logic [3:0]  rx_err,
  output logic             rx_ready,
  // Transmit shifter side
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_take,
  input  wire logic        sync_mode,
  input  wire logic        crc_done,
  // Interrupt and DMA
  output logic             irq,
  input  wire logic        iack,
  output logic [1:0]       vec_status,
  output logic             dma_rx_req
);
  chan_state_t s_q;
  chan_state_t s_d;
  rxq_if       rq ();

  logic        wr_fire;
  logic        rd_fire;
  cmd_t        cmd;
  logic        head_spec;
  logic        rx_empty;
  logic        do_pop;
  logic        tx_wr;
  logic        take;
  logic        shift_dn;
  logic        tx_evt;
  logic        tx_dec;
  logic        rx_req;
  logic        tx_req;
  logic        lock_mode;

  rx_store u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .q       (rq.store)
  );

  function automatic logic is_special(input logic [3:0] err, input logic par_en);
    is_special = |(err & {3'b111, par_en});
  endfunction : is_special

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h0, b};
  endfunction : byte_word

  always_comb begin
    s_d       = s_q;
    cmd       = CMD_NONE;
    tx_wr     = 1'b0;
    do_pop    = 1'b0;
    tx_evt    = 1'b0;
    tx_dec    = 1'b0;
    rx_empty  = (rq.count == 4'h0);
    head_spec = !rx_empty && is_special(rq.head_err, s_q.par_en);
    lock_mode = (s_q.mode == RX_FIRST) || (s_q.mode == RX_SPECIAL);

    // Write path: address and data taken in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.waddr  = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wbyte = wdata[7:0];
      s_d.wlane = wstrb[0];
    end
    wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `RESP_OKAY;
      unique case (s_q.waddr)
        `ADDR_CMD: begin
          if (s_q.wlane) begin
            cmd = cmd_t'(s_q.wbyte[2:0]);
          end
        end
        `ADDR_ICTL: begin
          if (s_q.wlane) begin
            s_d.tx_ie  = s_q.wbyte[`ICTL_TXIE];
            s_d.par_en = s_q.wbyte[`ICTL_PAR];
            s_d.mode   = rx_mode_t'(s_q.wbyte[`ICTL_MODE_HI:`ICTL_MODE_LO]);
          end
        end
        `ADDR_XOPT: begin
          if (s_q.wlane) begin
            s_d.rx_thr = s_q.wbyte[`XOPT_RXTHR];
            s_d.tx_lvl = s_q.wbyte[`XOPT_TXLVL];
          end
        end
        `ADDR_TXD: begin
          tx_wr = s_q.wlane && !s_q.entry_full;
        end
        `ADDR_STAT, `ADDR_SCST, `ADDR_RXD, `ADDR_VEC: begin
        end
        default: begin
          s_d.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;

    // Read path
    rd_fire = arvalid && s_q.arready;
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `RESP_OKAY;
      s_d.rdata  = 32'h0;
      unique case (araddr)
        `ADDR_CMD: begin
        end
        `ADDR_ICTL: begin
          s_d.rdata[`ICTL_TXIE] = s_q.tx_ie;
          s_d.rdata[`ICTL_PAR]  = s_q.par_en;
          s_d.rdata[`ICTL_MODE_HI:`ICTL_MODE_LO] = s_q.mode;
        end
        `ADDR_XOPT: begin
          s_d.rdata[`XOPT_RXTHR] = s_q.rx_thr;
          s_d.rdata[`XOPT_TXLVL] = s_q.tx_lvl;
        end
        `ADDR_STAT: begin
          s_d.rdata[`STAT_RXAV] = !rx_empty;
          s_d.rdata[`STAT_TEF]  = s_q.entry_free;
          s_d.rdata[`STAT_LOCK] = s_q.lock;
        end
        `ADDR_SCST: begin
          s_d.rdata = {28'h0, rq.head_err};
        end
        `ADDR_RXD: begin
          s_d.rdata = byte_word(rq.head_data);
          if (!rx_empty) begin
            s_d.first_pend = 1'b0;
            s_d.armed      = 1'b0;
            if (s_q.lock) begin
              do_pop = 1'b0;
            end else if (lock_mode && head_spec) begin
              s_d.lock    = 1'b1;
              s_d.special = 1'b1;
            end else begin
              do_pop = 1'b1;
            end
          end
        end
        `ADDR_TXD: begin
        end
        `ADDR_VEC: begin
          s_d.rdata[`VEC_RXP] = s_q.rx_pend;
          s_d.rdata[`VEC_TXP] = (s_q.tx_pend != 2'h0);
          s_d.rdata[`VEC_IUS] = s_q.in_service;
          s_d.rdata[`VEC_ST_HI:`VEC_ST_LO] = s_q.vstat;
        end
        default: begin
          s_d.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid;

    // Commands
    if (cmd == CMD_NEXT_CHR) begin
      s_d.armed = 1'b1;
    end
    if (cmd == CMD_ERR_RST && s_q.lock) begin
      s_d.lock    = 1'b0;
      s_d.special = 1'b0;
      do_pop      = 1'b1;
    end
    if (cmd == CMD_IUS_RST) begin
      s_d.in_service = 1'b0;
    end
    if (wr_fire && s_q.waddr == `ADDR_ICTL && s_q.wlane && s_d.mode == RX_FIRST && s_q.mode != RX_FIRST) begin
      s_d.armed = 1'b1;
    end
    if (!lock_mode && s_d.mode != RX_OFF) begin
      s_d.lock    = 1'b0;
      s_d.special = 1'b0;
    end

    // Receive pending per mode
    if (s_q.mode == RX_FIRST && s_d.armed && !rx_empty && !s_q.lock) begin
      s_d.first_pend = 1'b1;
    end
    unique case (s_q.mode)
      RX_OFF:     s_d.rx_pend = 1'b0;
      RX_FIRST:   s_d.rx_pend = s_d.first_pend || s_d.special;
      RX_ALL: begin
        if (s_q.rx_thr) begin
          s_d.rx_pend = (rq.count >= `RX_THRESHOLD) || head_spec;
        end else begin
          s_d.rx_pend = !rx_empty;
        end
      end
      RX_SPECIAL: s_d.rx_pend = s_d.special;
    endcase
    s_d.dma_req  = !s_d.lock && !rq.count[3] && (rq.count > 4'(do_pop));
    s_d.rx_ready = (rq.count != 4'h8) || do_pop;

    // Transmit store: entry location above a three-deep lower store
    take     = s_q.tx_valid && tx_take;
    s_d.tx_low = s_q.tx_low;
    if (take) begin
      s_d.tx_low[0] = s_q.tx_low[1];
      s_d.tx_low[1] = s_q.tx_low[2];
    end
    s_d.tx_cnt = 2'(s_q.tx_cnt - {1'b0, take});
    shift_dn = s_q.entry_full && (s_d.tx_cnt != `TX_LOW_FULL);
    if (shift_dn) begin
      s_d.tx_low[s_d.tx_cnt] = s_q.tx_entry;
      s_d.tx_cnt     = 2'(s_d.tx_cnt + 2'h1);
      s_d.entry_full = 1'b0;
    end
    if (tx_wr) begin
      s_d.tx_entry   = s_q.wbyte;
      s_d.entry_full = 1'b1;
      s_d.tx_written = 1'b1;
      tx_dec         = 1'b1;
    end
    if (cmd == CMD_TXP_RST) begin
      tx_dec = 1'b1;
    end
    if (s_q.tx_lvl) begin
      tx_evt = take && (s_q.tx_cnt == 2'h1) && !s_q.entry_full;
    end else begin
      tx_evt = shift_dn;
    end
    if (sync_mode && crc_done) begin
      tx_evt = 1'b1;
    end
    tx_evt = tx_evt && s_q.tx_written && s_q.tx_ie;
    if (tx_dec && s_q.tx_pend != 2'h0) begin
      s_d.tx_pend = 2'(s_q.tx_pend - 2'h1);
    end
    if (tx_evt && s_d.tx_pend != 2'h2) begin
      s_d.tx_pend = 2'(s_d.tx_pend + 2'h1);
    end
    s_d.entry_free = !s_d.entry_full;
    s_d.tx_valid   = (s_d.tx_cnt != 2'h0);
    s_d.tx_data    = s_d.tx_low[0];

    // Acknowledge and request
    rx_req = s_d.rx_pend && (s_q.mode != RX_OFF);
    tx_req = (s_d.tx_pend != 2'h0) && s_q.tx_ie;
    if (iack && s_q.irq && !s_q.in_service) begin
      s_d.in_service = 1'b1;
      if (s_q.rx_pend && s_q.mode != RX_OFF) begin
        s_d.vstat = s_q.special || (s_q.mode == RX_ALL && head_spec) ? VS_RX_SPEC : VS_RX_CHAR;
      end else begin
        s_d.vstat = VS_TX;
      end
    end
    s_d.irq = !s_d.in_service && (rx_req || tx_req);
  end

  assign rq.push      = rx_push;
  assign rq.push_data = rx_byte;
  assign rq.push_err  = rx_err;
  assign rq.pop       = do_pop;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q        <= '0;
      s_q.tx_lvl <= `TXLVL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready    = s_q.awready;
  assign wready     = s_q.wready;
  assign bvalid     = s_q.bvalid;
  assign bresp      = s_q.bresp;
  assign arready    = s_q.arready;
  assign rvalid     = s_q.rvalid;
  assign rdata      = s_q.rdata;
  assign rresp      = s_q.rresp;
  assign rx_ready   = s_q.rx_ready;
  assign tx_valid   = s_q.tx_valid;
  assign tx_data    = s_q.tx_data;
  assign irq        = s_q.irq;
  assign vec_status = s_q.vstat;
  assign dma_rx_req = s_q.dma_req;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_lock_holds_exit: assert property (s_q.lock && cmd != CMD_ERR_RST |-> !do_pop)
    else $error("exit byte moved while locked");
  chk_lock_stops_dma: assert property (s_q.lock |-> !dma_rx_req)
    else $error("dma request while locked");
  chk_unlock_by_reset: assert property (s_q.lock && cmd == CMD_ERR_RST |=> !s_q.lock)
    else $error("error reset left store locked");
  chk_all_no_lock: assert property (s_q.mode == RX_ALL && !s_q.lock |=> !s_q.lock)
    else $error("all mode locked the store");
  chk_all_exit: assert property (s_q.mode == RX_ALL && !s_q.rx_thr |=> s_q.rx_pend == !$past(rx_empty))
    else $error("all mode pending does not follow exit byte");
  chk_thresh_four: assert property (s_q.mode == RX_ALL && s_q.rx_thr && !head_spec
                                    |=> s_q.rx_pend == ($past(rq.count) >= `RX_THRESHOLD))
    else $error("threshold pending wrong");
  chk_lock_after_read: assert property (rd_fire && araddr == `ADDR_RXD && lock_mode && head_spec && !s_q.lock
                                        |=> s_q.lock && s_q.special ##1 s_q.rx_pend || s_q.mode != $past(s_q.mode))
    else $error("special byte read did not lock");
  chk_tx_gate: assert property (!s_q.tx_ie && s_q.tx_pend == 2'h0 |=> s_q.tx_pend == 2'h0)
    else $error("transmit event while disabled");
  chk_write_busy: assert property (tx_wr |=> !s_q.entry_free)
    else $error("entry free after write");
  chk_write_clears: assert property (tx_wr && s_q.tx_pend == 2'h1 && !tx_evt |=> s_q.tx_pend == 2'h0)
    else $error("write did not clear transmit pending");
  chk_crc_stacks: assert property (tx_evt && s_q.tx_pend == 2'h1 && !tx_dec |=> s_q.tx_pend == 2'h2)
    else $error("crc interrupt not stacked");
  chk_level_reset: assert property (!$past(aresetn) |-> s_q.tx_lvl)
    else $error("level option not set after reset");

  cov_locked: cover property (s_q.lock ##1 cmd == CMD_ERR_RST);
  cov_two_tx: cover property (s_q.tx_pend == 2'h2);
  cov_first: cover property (s_q.mode == RX_FIRST && s_q.first_pend ##[1:20] irq);
endmodule : serial_irq

// ### sim/tx_shifter_model.sv
// Transmit shifter model that takes bytes from the transmit exit
`timescale 1ns/1ps
module tx_shifter_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Transmit exit
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_take,
  // Bench control and observation
  input  wire logic       stall,
  output logic [7:0]      n_taken,
  output logic [7:0]      last_byte
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_take   <= 1'b0;
      n_taken   <= 8'h00;
      last_byte <= 8'h00;
    end else begin
      // Never two takes in a row, so the shifter is slower than the store
      tx_take <= tx_valid && !stall && !tx_take;
      if (tx_valid && tx_take) begin
        n_taken   <= n_taken + 8'h01;
        last_byte <= tx_data;
      end
    end
  end
endmodule : tx_shifter_model

// ### sim/test_serial_rx_tx_interrupt_logic.sv
// Self-checking testbench of the serial interrupt block
`timescale 1ns/1ps
`include "serial_irq_regs.svh"
module test_serial_rx_tx_interrupt_logic;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, rx_byte, tx_data, n_taken, last_byte;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0]  bresp, rresp, resp_q, vec_status;
  logic [3:0]  rx_err;
  logic        awready, wready, bvalid, arready, rvalid, rx_push, rx_ready;
  logic        tx_valid, tx_take, sync_mode, crc_done, stall, irq, iack, dma_rx_req;
  int          n_fail, cmp_count;

  serial_irq u_serial_irq (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .rx_push(rx_push), .rx_byte(rx_byte), .rx_err(rx_err), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take), .sync_mode(sync_mode),
    .crc_done(crc_done), .irq(irq), .iack(iack), .vec_status(vec_status), .dma_rx_req(dma_rx_req)
  );
  tx_shifter_model u_tx_shifter_model (
    .aclk(aclk), .aresetn(aresetn), .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take),
    .stall(stall), .n_taken(n_taken), .last_byte(last_byte)
  );

  always #5 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp_q = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(nm, rd_q & m, e);
  endtask : rc

  task automatic push(input logic [7:0] b, input logic [3:0] e);
    @(posedge aclk);
    rx_push <= 1'b1;
    rx_byte <= b;
    rx_err  <= e;
    @(posedge aclk);
    rx_push <= 1'b0;
  endtask : push

  task automatic t_reset;
    rc("ext option", `ADDR_XOPT, 32'hff, 32'h20);
    rc("pending", `ADDR_VEC, 32'h3f, 32'h0);
    rc("lock", `ADDR_STAT, 32'h8, 32'h0);
    chk("read resp", {30'h0, resp_q}, {30'h0, `RESP_OKAY});
    rd(8'h20);
    chk("unmapped rresp", {30'h0, resp_q}, {30'h0, `RESP_SLVERR});
    wr(8'h20, 32'h0);
    chk("unmapped bresp", {30'h0, resp_q}, {30'h0, `RESP_SLVERR});
  endtask : t_reset

  task automatic t_first_char;
    wr(`ADDR_ICTL, 32'h08);
    push(8'h41, 4'h0);
    push(8'h42, 4'h0);
    rc("first pend", `ADDR_VEC, 32'h1, 32'h1);
    rc("data a", `ADDR_RXD, 32'hff, 32'h41);
    rc("silent after first", `ADDR_VEC, 32'h1, 32'h0);
    wr(`ADDR_CMD, 32'h1);
    rc("next char pend", `ADDR_VEC, 32'h1, 32'h1);
    rc("data b", `ADDR_RXD, 32'hff, 32'h42);
    rc("pend on removal", `ADDR_VEC, 32'h1, 32'h0);
  endtask : t_first_char

  task automatic t_special_lock;
    push(8'h43, 4'h8);
    push(8'h44, 4'h0);
    rc("no early special", `ADDR_VEC, 32'h1, 32'h0);
    #1 chk("dma open", {31'h0, dma_rx_req}, 32'h1);
    rc("data c", `ADDR_RXD, 32'hff, 32'h43);
    rc("special pend", `ADDR_VEC, 32'h1, 32'h1);
    rc("locked", `ADDR_STAT, 32'h8, 32'h8);
    #1 chk("dma held", {31'h0, dma_rx_req}, 32'h0);
    rc("special status", `ADDR_SCST, 32'hf, 32'h8);
    rc("reread c", `ADDR_RXD, 32'hff, 32'h43);
    push(8'h45, 4'h0);
    #1 chk("irq special", {31'h0, irq}, 32'h1);
    chk("room while locked", {31'h0, rx_ready}, 32'h1);
    @(posedge aclk);
    iack <= 1'b1;
    @(posedge aclk);
    iack <= 1'b0;
    cyc(1);
    #1 chk("vector special", {30'h0, vec_status}, 32'h3);
    chk("irq in service", {31'h0, irq}, 32'h0);
    wr(`ADDR_CMD, 32'h4);
    wr(`ADDR_CMD, 32'h2);
    rc("unlocked", `ADDR_STAT, 32'h8, 32'h0);
    wr(`ADDR_CMD, 32'h1);
    rc("next frame pend", `ADDR_VEC, 32'h1, 32'h1);
    rc("data d", `ADDR_RXD, 32'hff, 32'h44);
    rc("data e", `ADDR_RXD, 32'hff, 32'h45);
    rc("store empty", `ADDR_STAT, 32'h1, 32'h0);
  endtask : t_special_lock

  task automatic t_all_chars;
    wr(`ADDR_ICTL, 32'h10);
    push(8'h50, 4'h0);
    rc("all pend", `ADDR_VEC, 32'h1, 32'h1);
    push(8'h51, 4'h4);
    rc("data 50", `ADDR_RXD, 32'hff, 32'h50);
    rc("all pend err", `ADDR_VEC, 32'h1, 32'h1);
    rc("no lock", `ADDR_STAT, 32'h8, 32'h0);
    rc("status first", `ADDR_SCST, 32'hf, 32'h4);
    rc("data 51", `ADDR_RXD, 32'hff, 32'h51);
    rc("all clear", `ADDR_VEC, 32'h1, 32'h0);
    wr(`ADDR_XOPT, 32'h28);
    for (int i = 0; i < 3; i++) push(8'h60 + 8'(i), 4'h0);
    rc("three below", `ADDR_VEC, 32'h1, 32'h0);
    push(8'h63, 4'h0);
    rc("four pend", `ADDR_VEC, 32'h1, 32'h1);
    rc("data 60", `ADDR_RXD, 32'hff, 32'h60);
    rc("below four", `ADDR_VEC, 32'h1, 32'h0);
    for (int i = 1; i < 4; i++) rc("drain", `ADDR_RXD, 32'hff, 32'h60 + i);
    wr(`ADDR_XOPT, 32'h20);
  endtask : t_all_chars

  task automatic t_special_only;
    wr(`ADDR_ICTL, 32'h1c);
    push(8'h70, 4'h0);
    rc("plain no pend", `ADDR_VEC, 32'h1, 32'h0);
    #1 chk("dma plain", {31'h0, dma_rx_req}, 32'h1);
    rc("data 70", `ADDR_RXD, 32'hff, 32'h70);
    rc("still none", `ADDR_VEC, 32'h1, 32'h0);
    push(8'h71, 4'h1);
    rc("parity no early", `ADDR_VEC, 32'h1, 32'h0);
    rc("data 71", `ADDR_RXD, 32'hff, 32'h71);
    rc("parity pend", `ADDR_VEC, 32'h1, 32'h1);
    #1 chk("dma parity held", {31'h0, dma_rx_req}, 32'h0);
    wr(`ADDR_CMD, 32'h2);
    rc("parity cleared", `ADDR_VEC, 32'h1, 32'h0);
  endtask : t_special_only

  task automatic t_tx_empty;
    wr(`ADDR_ICTL, 32'h0);
    wr(`ADDR_TXD, 32'h81);
    cyc(10);
    rc("tx gated", `ADDR_VEC, 32'h2, 32'h0);
    wr(`ADDR_ICTL, 32'h2);
    wr(`ADDR_TXD, 32'h82);
    cyc(10);
    rc("tx empty pend", `ADDR_VEC, 32'h2, 32'h2);
    #1 chk("irq tx", {31'h0, irq}, 32'h1);
    chk("bytes sent", {24'h0, n_taken}, 32'h2);
    chk("last sent", {24'h0, last_byte}, 32'h82);
    wr(`ADDR_CMD, 32'h3);
    rc("tx reset cmd", `ADDR_VEC, 32'h2, 32'h0);
  endtask : t_tx_empty

  task automatic t_tx_level_sync;
    wr(`ADDR_XOPT, 32'h0);
    @(posedge aclk);
    stall <= 1'b1;
    for (int i = 0; i < 3; i++) wr(`ADDR_TXD, 32'h90 + i);
    cyc(2);
    rc("level req", `ADDR_VEC, 32'h2, 32'h2);
    rc("entry free", `ADDR_STAT, 32'h4, 32'h4);
    wr(`ADDR_TXD, 32'h93);
    cyc(2);
    rc("full no req", `ADDR_VEC, 32'h2, 32'h0);
    rc("entry full", `ADDR_STAT, 32'h4, 32'h0);
    @(posedge aclk);
    sync_mode <= 1'b1;
    stall     <= 1'b0;
    cyc(20);
    rc("entry free again", `ADDR_STAT, 32'h4, 32'h4);
    rc("req after shift", `ADDR_VEC, 32'h2, 32'h2);
    chk("bytes sent", {24'h0, n_taken}, 32'h6);
    @(posedge aclk);
    crc_done <= 1'b1;
    @(posedge aclk);
    crc_done <= 1'b0;
    rc("crc entry free", `ADDR_STAT, 32'h4, 32'h4);
    wr(`ADDR_CMD, 32'h3);
    rc("crc latched", `ADDR_VEC, 32'h2, 32'h2);
    wr(`ADDR_CMD, 32'h3);
    rc("second reset", `ADDR_VEC, 32'h2, 32'h0);
  endtask : t_tx_level_sync

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata, rx_push, rx_byte, rx_err} = '0;
    {sync_mode, crc_done, stall, iack, n_fail, cmp_count} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_first_char();
    t_special_lock();
    t_all_chars();
    t_special_only();
    t_tx_empty();
    t_tx_level_sync();
    final_report();
  end
endmodule : test_serial_rx_tx_interrupt_logic
